// *** sac_pkg.sv ***
package sac_pkg;
   // Period of clk in nanoseconds; clk runs at 250 MHz.
   localparam int CLK_NS = 4;
   // Cycles from a start pin edge to the block acting on it (three-stage filter plus edge).
   localparam int SYNC_LAT = 4;
   // Width of the result word.
   localparam int RES_BITS = 16;
   // Width of the sequencing counters.
   localparam int CNT_W = 12;
   // Width of the serial clock phase counters.
   localparam int PH_W = 6;

   // Conversion time per speed mode in ns: fastest, normal, low power.
   localparam int CONV_NS [3] = '{750, 1000, 1250};
   // Start edge to frame strobe in read-during-convert, in ns.
   localparam int RDC_SYNC_NS [3] = '{25, 275, 525};
   // Result valid before busy falls, in ns.
   localparam int DATA_LEAD_NS = 45;
   // Frame strobe removal to busy low in read-after-convert, in ns.
   localparam int SYNC_TO_IDLE_NS = 25;
   // Serial clock figures per divider select, in ns.
   localparam int SCLK_PER_NS [4] = '{25, 50, 100, 200};
   localparam int SCLK_HIGH_NS [4] = '{12, 22, 50, 100};
   localparam int SCLK_LOW_NS [4] = '{7, 21, 49, 99};
   localparam int FIRST_EDGE_NS [4] = '{3, 17, 17, 17};
   localparam int LAST_EDGE_NS [4] = '{3, 60, 140, 300};

   // Converts a least time to cycles, rounding up, never below one.
   function automatic int ns_up(input int ns);
      return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
   endfunction : ns_up

   // Converts a longest time to cycles, rounding down, never below one.
   function automatic int ns_dn(input int ns);
      return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
   endfunction : ns_dn

   localparam int DATA_LEAD_CYC = ns_up(DATA_LEAD_NS);
   localparam int SYNC_TO_IDLE_CYC = ns_dn(SYNC_TO_IDLE_NS);

   // Maps the speed field to a table index; the spare code acts as low power.
   function automatic int spd_idx(input logic [1:0] spd);
      return (spd == 2'h3) ? 2 : int'(spd);
   endfunction : spd_idx

   // Counter value at which a conversion ends.
   function automatic logic [CNT_W-1:0] conv_end(input logic [1:0] spd);
      return CNT_W'(ns_dn(CONV_NS[spd_idx(spd)]) - SYNC_LAT);
   endfunction : conv_end

   // Counter value at which the result is latched.
   function automatic logic [CNT_W-1:0] latch_pt(input logic [1:0] spd);
      return CNT_W'(ns_dn(CONV_NS[spd_idx(spd)]) - SYNC_LAT - DATA_LEAD_CYC);
   endfunction : latch_pt

   // Counter value at which a read-during-convert frame opens.
   function automatic logic [CNT_W-1:0] rdc_pt(input logic [1:0] spd);
      int v;
      v = ns_dn(RDC_SYNC_NS[spd_idx(spd)]) - SYNC_LAT;
      return CNT_W'((v < 1) ? 1 : v);
   endfunction : rdc_pt

   // Low phase of the serial clock in cycles.
   function automatic logic [PH_W-1:0] sclk_low(input logic [1:0] d);
      return PH_W'(ns_up(SCLK_LOW_NS[d]));
   endfunction : sclk_low

   // High phase, stretched so that the whole period meets its minimum.
   function automatic logic [PH_W-1:0] sclk_high(input logic [1:0] d);
      int hi;
      hi = ns_up(SCLK_PER_NS[d]) - ns_up(SCLK_LOW_NS[d]);
      return PH_W'((hi > ns_up(SCLK_HIGH_NS[d])) ? hi : ns_up(SCLK_HIGH_NS[d]));
   endfunction : sclk_high

   // Frame strobe to first serial clock edge, in cycles.
   function automatic logic [CNT_W-1:0] lead_cyc(input logic [1:0] d);
      return CNT_W'(ns_up(FIRST_EDGE_NS[d]));
   endfunction : lead_cyc

   // Last serial clock edge to frame strobe removal, in cycles.
   function automatic logic [CNT_W-1:0] trail_cyc(input logic [1:0] d);
      return CNT_W'(ns_up(LAST_EDGE_NS[d]));
   endfunction : trail_cyc

   // Output port modes.
   typedef enum logic [1:0] {
      PORT_PARALLEL = 2'b00,
      PORT_SER_RDC = 2'b01,
      PORT_SER_RAC = 2'b10,
      PORT_SER_SLAVE = 2'b11
   } sac_port_t;

   // Master serial frame states.
   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_LEAD = 3'b001,
      SER_SHIFT = 3'b010,
      SER_TRAIL = 3'b011,
      SER_TAIL = 3'b100
   } sac_ser_t;

   // Register byte offsets and fields.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RESULT = 4'h8;
   localparam int CTRL_SPD_LSB = 0;
   localparam int CTRL_DIV_LSB = 2;
   localparam int CTRL_PORT_LSB = 4;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam int ST_BUSY = 0;
   localparam int ST_FRAME = 1;
   localparam int ST_DONE = 2;
   localparam int ST_EARLY = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sac_pkg

// *** sac_sync.sv ***
module sac_sync #(
   parameter logic RESET_LEVEL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level
);
   // Three sampling stages; the first is read only by the second.
   logic [2:0] stage;

   // Shifts the pin through the stages.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage <= {3{RESET_LEVEL}};
      end else begin
         stage <= {stage[1:0], pin};
      end
   end

   // Accepts a change only once the second and third stages agree.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level <= RESET_LEVEL;
      end else if (stage[1] == stage[2]) begin
         level <= stage[2];
      end
   end
endmodule : sac_sync

// *** sac_sclk_gen.sv ***
module sac_sclk_gen
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [PH_W-1:0] low_cyc,
   input wire logic [PH_W-1:0] high_cyc,
   output logic sclk,
   output logic fall
);
   // Cycles spent in the current phase.
   logic [PH_W-1:0] cnt;

   // Announces a falling edge one cycle ahead.
   assign fall = run && sclk && (cnt == high_cyc - 1'b1);

   // Runs low then high phases while enabled; rests low otherwise.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= '0;
         sclk <= 1'b0;
      end else if (!run) begin
         cnt <= '0;
         sclk <= 1'b0;
      end else if (cnt == (sclk ? high_cyc : low_cyc) - 1'b1) begin
         cnt <= '0;
         sclk <= ~sclk;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule : sac_sclk_gen

// *** sac_converter.sv ***
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
module sac_converter
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic convert_start_n,
   input wire logic cs_b,
   input wire logic rd_b,
   input wire logic ext_sclk,
   input wire logic chain_data_in,
   input wire logic [RES_BITS-1:0] sample_code,
   output logic busy,
   output logic [RES_BITS-1:0] par_data,
   output logic par_data_oe_b,
   output logic frame_sync,
   output logic frame_sync_oe_b,
   output logic sclk_out,
   output logic sclk_oe_b,
   output logic serial_result_out,
   output logic serial_result_oe_b
);
   // Filtered pin levels and their previous values.
   logic cnv_lvl, cnv_prev, cs_lvl, esclk_lvl, esclk_prev, chain_lvl;
   // Control fields: speed mode, clock divider select, port mode.
   logic [1:0] speed, clock_divider_select;
   sac_port_t port;
   // Conversion sequencing.
   logic conv_run, start_evt, conv_done, rdc_go, rac_go, tail_end;
   logic [CNT_W-1:0] conv_cnt;
   // Sticky status flags.
   logic done_flag, early_flag;
   // Master serial frame state.
   sac_ser_t ser_state;
   logic [CNT_W-1:0] ph_cnt;
   logic [4:0] bit_cnt;
   logic rac_frame, sclk_fall, esclk_fall;
   logic [1:0] m_div;
   // Output shift register shared by master and slave modes.
   logic [RES_BITS-1:0] sh;
   // Register bus holding state.
   logic aw_got, w_got, wr_do;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   sac_sync #(.RESET_LEVEL(1'b1)) u_cnv_sync (.clk(clk), .rst_b(rst_b),
      .pin(convert_start_n), .level(cnv_lvl));
   sac_sync #(.RESET_LEVEL(1'b1)) u_cs_sync (.clk(clk), .rst_b(rst_b),
      .pin(cs_b), .level(cs_lvl));
   sac_sync #(.RESET_LEVEL(1'b0)) u_esclk_sync (.clk(clk), .rst_b(rst_b),
      .pin(ext_sclk), .level(esclk_lvl));
   sac_sync #(.RESET_LEVEL(1'b0)) u_chain_sync (.clk(clk), .rst_b(rst_b),
      .pin(chain_data_in), .level(chain_lvl));

   // Read-during-convert always runs at the fastest divider timing.
   assign m_div = (port == PORT_SER_RAC) ? clock_divider_select : 2'h0;

   sac_sclk_gen u_sclk (.clk(clk), .rst_b(rst_b), .run(ser_state == SER_SHIFT),
      .low_cyc(sclk_low(m_div)), .high_cyc(sclk_high(m_div)), .sclk(sclk_out),
      .fall(sclk_fall));

   // Event decodes.
   assign start_evt = cnv_prev && !cnv_lvl;
   assign esclk_fall = esclk_prev && !esclk_lvl;
   assign conv_done = conv_run && (conv_cnt == conv_end(speed));
   assign rdc_go = (port == PORT_SER_RDC) && conv_run && (conv_cnt == rdc_pt(speed))
      && (ser_state == SER_IDLE);
   assign rac_go = (port == PORT_SER_RAC) && conv_done;
   assign tail_end = (ser_state == SER_TAIL) && (ph_cnt == CNT_W'(SYNC_TO_IDLE_CYC - 1));

   // Pin-facing enables act straight from the pins so the drive turns quickly.
   assign par_data_oe_b = cs_b || rd_b || (port != PORT_PARALLEL);
   assign frame_sync_oe_b = cs_b || !(port == PORT_SER_RDC || port == PORT_SER_RAC);
   assign sclk_oe_b = frame_sync_oe_b;
   assign serial_result_oe_b = cs_b || (port == PORT_PARALLEL);
   assign serial_result_out = sh[RES_BITS-1];

   // Keeps previous pin levels for edge detection.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnv_prev <= 1'b1;
         esclk_prev <= 1'b0;
      end else begin
         cnv_prev <= cnv_lvl;
         esclk_prev <= esclk_lvl;
      end
   end

   // Conversion counter; a start while busy is ignored. Conversion timing is counted here, frame timing in ph_cnt.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_run <= 1'b0;
         conv_cnt <= '0;
      end else if (start_evt && !busy) begin
         conv_run <= 1'b1;
         conv_cnt <= CNT_W'(1);
      end else if (conv_done) begin
         conv_run <= 1'b0;
      end else if (conv_run) begin
         conv_cnt <= conv_cnt + 1'b1;
      end
   end

   // Busy rises right after start and falls at conversion or readout end.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'b0;
      end else if (start_evt && !busy) begin
         busy <= 1'b1;
      end else if (conv_done && port != PORT_SER_RAC) begin
         busy <= 1'b0;
      end else if (tail_end && rac_frame) begin
         busy <= 1'b0;
      end
   end

   // Latches the result a fixed lead ahead of the conversion end.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         par_data <= '0;
      end else if (conv_run && conv_cnt == latch_pt(speed)) begin
         par_data <= sample_code;
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done_flag <= 1'b0;
         early_flag <= 1'b0;
      end else begin
         if (conv_done) begin
            done_flag <= 1'b1;
         end else if (wr_do && aw_addr[3:2] == REG_STATUS[3:2] && w_strb[0]
            && w_data[ST_DONE]) begin
            done_flag <= 1'b0;
         end
         if (start_evt && busy) begin
            early_flag <= 1'b1;
         end else if (wr_do && aw_addr[3:2] == REG_STATUS[3:2] && w_strb[0]
            && w_data[ST_EARLY]) begin
            early_flag <= 1'b0;
         end
      end
   end

   // Master serial frame sequencer.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ser_state <= SER_IDLE;
         ph_cnt <= '0;
         bit_cnt <= '0;
         frame_sync <= 1'b0;
         rac_frame <= 1'b0;
      end else begin
         case (ser_state)
            SER_IDLE: begin
               if (rdc_go || rac_go) begin
                  ser_state <= SER_LEAD;
                  frame_sync <= 1'b1;
                  rac_frame <= rac_go;
                  ph_cnt <= '0;
                  bit_cnt <= '0;
               end
            end
            SER_LEAD: begin
               if (ph_cnt == lead_cyc(m_div) - 1'b1) begin
                  ser_state <= SER_SHIFT;
                  ph_cnt <= '0;
               end else begin
                  ph_cnt <= ph_cnt + 1'b1;
               end
            end
            SER_SHIFT: begin
               if (sclk_fall) begin
                  bit_cnt <= bit_cnt + 1'b1;
                  if (bit_cnt == 5'(RES_BITS - 1)) begin
                     ser_state <= SER_TRAIL;
                  end
               end
            end
            SER_TRAIL: begin
               if (ph_cnt == trail_cyc(m_div) - 1'b1) begin
                  ser_state <= SER_TAIL;
                  frame_sync <= 1'b0;
                  ph_cnt <= '0;
               end else begin
                  ph_cnt <= ph_cnt + 1'b1;
               end
            end
            SER_TAIL: begin
               if (tail_end) begin
                  ser_state <= SER_IDLE;
                  rac_frame <= 1'b0;
               end else begin
                  ph_cnt <= ph_cnt + 1'b1;
               end
            end
            default: begin
               ser_state <= SER_IDLE;
            end
         endcase
      end
   end

   // Shift register: loaded at frame open or conversion end, shifted per edge.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh <= '0;
      end else if (rdc_go || rac_go) begin
         sh <= par_data;
      end else if (port == PORT_SER_SLAVE && conv_done) begin
         sh <= par_data;
      end else if (ser_state == SER_SHIFT && sclk_fall) begin
         sh <= {sh[RES_BITS-2:0], 1'b0};
      end else if (port == PORT_SER_SLAVE && esclk_fall && !cs_lvl) begin
         sh <= {sh[RES_BITS-2:0], chain_lvl};
      end
   end

   // Control register; the host keeps it still during activity.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         speed <= CTRL_RESET[CTRL_SPD_LSB +: 2];
         clock_divider_select <= CTRL_RESET[CTRL_DIV_LSB +: 2];
         port <= sac_port_t'(CTRL_RESET[CTRL_PORT_LSB +: 2]);
      end else if (wr_do && aw_addr[3:2] == REG_CTRL[3:2] && w_strb[0]) begin
         speed <= w_data[CTRL_SPD_LSB +: 2];
         clock_divider_select <= w_data[CTRL_DIV_LSB +: 2];
         port <= sac_port_t'(w_data[CTRL_PORT_LSB +: 2]);
      end
   end

   // Write channel: address and data taken in either order, answered after both.
   assign awready = !aw_got && !bvalid;
   assign wready = !w_got && !bvalid;
   assign wr_do = aw_got && w_got;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_got <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (wr_do) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (aw_addr[3:2] == REG_CTRL[3:2] || aw_addr[3:2] == REG_STATUS[3:2])
               ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read channel: data registered the cycle after the address is taken.
   assign arready = !rvalid;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         case (araddr[3:2])
            REG_CTRL[3:2]: rdata <= {26'h0, port, clock_divider_select, speed};
            REG_STATUS[3:2]: rdata <= {28'h0, early_flag, done_flag, frame_sync, busy};
            REG_RESULT[3:2]: rdata <= {16'h0, par_data};
            default: begin
               rdata <= '0;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // Cycle counters read only by the checks below.
   logic [CNT_W-1:0] busy_len, frame_len, per_len, fall_len;
   logic sclk_d, seen_rise;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_len <= '0;
         frame_len <= '0;
         per_len <= '0;
         fall_len <= '0;
         sclk_d <= 1'b0;
         seen_rise <= 1'b0;
      end else begin
         busy_len <= busy ? busy_len + 1'b1 : '0;
         frame_len <= frame_sync ? frame_len + 1'b1 : '0;
         per_len <= (sclk_out && !sclk_d) ? CNT_W'(1) : per_len + 1'b1;
         fall_len <= (!sclk_out && sclk_d) ? CNT_W'(1) : fall_len + 1'b1;
         sclk_d <= sclk_out;
         seen_rise <= frame_sync && (seen_rise || sclk_out);
      end
   end

   property p_busy_rise;
      @(posedge clk) disable iff (!rst_b) start_evt && !busy |=> busy && conv_cnt == 1;
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy late after start");
   property p_early;
      @(posedge clk) disable iff (!rst_b) start_evt && busy |=> early_flag;
   endproperty
   a_early: assert property (p_early) else $error("early start not flagged");
   property p_busy_max;
      @(posedge clk) disable iff (!rst_b)
         busy && port != PORT_SER_RAC |-> busy_len < conv_end(speed);
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy held too long");
   property p_data_lead;
      @(posedge clk) disable iff (!rst_b) $fell(busy) && port == PORT_PARALLEL
         |-> par_data == $past(par_data, 11);
   endproperty
   a_data_lead: assert property (p_data_lead) else $error("result changed near busy fall");
   property p_rdc_sync;
      @(posedge clk) disable iff (!rst_b) rdc_go |=> frame_sync && ser_state == SER_LEAD;
   endproperty
   a_rdc_sync: assert property (p_rdc_sync) else $error("frame missed in read during");
   property p_rac_sync;
      @(posedge clk) disable iff (!rst_b) $rose(frame_sync) && rac_frame |-> !conv_run && busy;
   endproperty
   a_rac_sync: assert property (p_rac_sync) else $error("frame before conversion end");
   property p_first_edge;
      @(posedge clk) disable iff (!rst_b) $rose(sclk_out) && !seen_rise
         |-> frame_len >= lead_cyc(m_div);
   endproperty
   a_first_edge: assert property (p_first_edge) else $error("first serial edge too soon");
   property p_period;
      @(posedge clk) disable iff (!rst_b) $rose(sclk_out) && seen_rise
         |-> per_len == CNT_W'(sclk_low(m_div)) + CNT_W'(sclk_high(m_div));
   endproperty
   a_period: assert property (p_period) else $error("serial clock period wrong");
   property p_trail;
      @(posedge clk) disable iff (!rst_b) $fell(frame_sync) |-> fall_len >= trail_cyc(m_div);
   endproperty
   a_trail: assert property (p_trail) else $error("frame removed too soon");
   property p_busy_tail;
      @(posedge clk) disable iff (!rst_b) $fell(frame_sync) && rac_frame |-> busy[*6] ##1 !busy;
   endproperty
   a_busy_tail: assert property (p_busy_tail) else $error("busy fall not after frame");
   property p_float;
      @(posedge clk) disable iff (!rst_b) cs_b |-> frame_sync_oe_b && serial_result_oe_b;
   endproperty
   a_float: assert property (p_float) else $error("serial pins driven while deselected");
   property p_slave_shift;
      @(posedge clk) disable iff (!rst_b) port == PORT_SER_SLAVE && esclk_fall && !cs_lvl
         && !conv_done |=> serial_result_out == $past(sh[RES_BITS-2]);
   endproperty
   a_slave_shift: assert property (p_slave_shift) else $error("slave bit not advanced");
endmodule : sac_converter

// *** sac_host_model.sv ***
module sac_host_model
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic early,
   input wire logic sclk_out,
   input wire logic frame_sync,
   input wire logic serial_result_out,
   output logic convert_start_n,
   output logic [RES_BITS-1:0] shift
);
   timeunit 1ns;
   timeprecision 1ps;
   // Cycles since the last start strobe; starts far from any strobe.
   int gap = 1000;
   initial convert_start_n = 1'b1;
   // A strobe of three cycles, normally never sooner than the slowest mode's spacing.
   always @(posedge clk) begin
      gap <= gap + 1;
      // A hurried host breaks the spacing on purpose, to show that the block refuses it.
      if (go && gap > (early ? 60 : 400)) gap <= 0;
      convert_start_n <= (gap >= 3);
   end
   // Result bits are taken on each rising serial clock edge inside a frame.
   always @(posedge sclk_out) begin
      if (frame_sync) shift <= {shift[RES_BITS-2:0], serial_result_out};
   end
endmodule : sac_host_model

// *** test_sac_converter.sv ***
module test_sac_converter
   import sac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, busy, par_data_oe_b, frame_sync;
   logic sclk_out, sclk_oe_b, serial_result_out, serial_result_oe_b, frame_sync_oe_b;
   logic go = 0, cs_b = 1, rd_b = 1, ext_sclk = 0, chain_data_in = 0, convert_start_n;
   logic early = 0;
   logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   logic [RES_BITS-1:0] sample_code = 0, par_data, shift, prev;
   int err_count = 0, checked = 0, w;
   int pl[3] = '{187, 250, 312};
   int sl[4] = '{375, 500, 750, 1312};
   sac_converter i_sac_converter (.clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .convert_start_n, .cs_b, .rd_b, .ext_sclk, .chain_data_in, .sample_code,
      .busy, .par_data, .par_data_oe_b, .frame_sync, .frame_sync_oe_b, .sclk_out, .sclk_oe_b,
      .serial_result_out, .serial_result_oe_b);
   sac_host_model i_sac_host_model (.clk, .go, .early, .sclk_out, .frame_sync,
      .serial_result_out, .convert_start_n, .shift);
   // The clock toggles every 2 ns.
   initial forever #2 clk = ~clk;
   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Bus write; address and data are released each as it is taken.
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta = 0, tw = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while ((ta & tw) !== 1'b1) begin
         @(negedge clk);
         ta |= awready;
         tw |= wready;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      do begin
         @(negedge clk);
         ta = bvalid;
         @(posedge clk);
      end while (ta !== 1'b1);
      bready <= 1'b0;
      chk(bresp, r);
   endtask : axw
   // Bus read with data and response compared.
   task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      logic t;
      logic [31:0] d;
      logic [1:0] rr;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         t = arready;
         @(posedge clk);
      end while (t !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(negedge clk);
         t = rvalid;
         d = rdata;
         rr = rresp;
         @(posedge clk);
      end while (t !== 1'b1);
      rready <= 1'b0;
      chk(d, e);
      chk(rr, r);
   endtask : axr
   // One conversion; n is the busy width in cycles.
   task automatic conv(output int n);
      go <= 1'b1;
      do @(negedge clk); while (convert_start_n);
      @(posedge clk) go <= 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 9) begin
         @(negedge clk);
         n++;
      end
      chk(n <= 7, 1);
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
   endtask : conv
   // Ends the run with the counts and the verdict.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // Cuts a hang short.
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      axr(REG_CTRL, 0, RESP_OKAY);
      axr(4'hc, 0, RESP_SLVERR);
      axw(REG_RESULT, 1, RESP_SLVERR);
      $display("registers done");
      for (int s = 0; s < 3; s++) begin
         sample_code <= {4{4'(s)}} ^ 16'h9a35;
         axw(REG_CTRL, s, RESP_OKAY);
         conv(w);
         chk(w <= pl[s], 1);
         chk(par_data, {4{4'(s)}} ^ 16'h9a35);
         @(posedge clk) {cs_b, rd_b} <= 2'b00;
         @(negedge clk) chk(par_data_oe_b, 0);
         @(posedge clk) {cs_b, rd_b} <= 2'b11;
         @(negedge clk) chk(par_data_oe_b, 1);
      end
      axr(REG_STATUS, 32'h4, RESP_OKAY);
      $display("parallel done");
      cs_b <= 1'b0;
      for (int d = 0; d < 4; d++) begin
         sample_code <= 16'hc3a6 ^ 16'(d);
         axw(REG_CTRL, 32'h20 | (d << 2), RESP_OKAY);
         conv(w);
         chk(w <= sl[d], 1);
         chk(shift, 16'hc3a6 ^ 16'(d));
      end
      prev = sample_code;
      sample_code <= 16'h5e71;
      axw(REG_CTRL, 32'h10, RESP_OKAY);
      conv(w);
      chk(shift, prev);
      chk({frame_sync_oe_b, sclk_oe_b, serial_result_oe_b}, 0);
      @(posedge clk) cs_b <= 1'b1;
      @(negedge clk) chk({frame_sync_oe_b, sclk_oe_b, serial_result_oe_b}, 3'b111);
      $display("master serial done");
      @(posedge clk) cs_b <= 1'b0;
      axw(REG_CTRL, 32'h30, RESP_OKAY);
      chain_data_in <= 1'b1;
      conv(w);
      chk(w <= pl[0], 1);
      chk({frame_sync_oe_b, sclk_oe_b, serial_result_oe_b}, 3'b110);
      for (int i = 15; i >= 0; i--) begin
         @(negedge clk) chk(serial_result_out, sample_code[i]);
         @(posedge clk) ext_sclk <= 1'b1;
         repeat (4) @(posedge clk);
         ext_sclk <= 1'b0;
         repeat (8) @(posedge clk);
      end
      @(negedge clk) chk(serial_result_out, 1);
      $display("slave serial done");
      @(posedge clk) go <= 1'b1;
      early <= 1'b1;
      repeat (120) @(posedge clk);
      go <= 1'b0;
      repeat (200) @(posedge clk);
      axr(REG_STATUS, 32'hc, RESP_OKAY);
      axw(REG_STATUS, 32'hc, RESP_OKAY);
      axr(REG_STATUS, 32'h0, RESP_OKAY);
      $display("flags done");
      tally_and_finish();
   end
endmodule : test_sac_converter
